//--- design/sixteen_bit_pwm_trio.sv
`timescale 1ns/1ps
// Summary of operation
// - Three identical independent channels each count on a 16-bit base counter.
// - Clock-source codes 00 and 01 pick the system clock, 10 the fast oscillator, 11 twice it.
// - A low-byte write only fills the holding latch and the high-byte write commits 16 bits.
// - A high-byte read copies the low byte into the latch which a later low-byte read returns.
// - With output enable 0 a channel is cleared and stopped, with 1 it drives its pin and runs unless its clear bit is 1.
// - While a channel's clear bit is 1 the channel is cleared and held.
// - The output goes low when the base counter equals the duty value.
// - The period register pair sets the length of the waveform period.
// - New duty and period values wait in buffers until period end, or load at once when cleared.
// - Each channel sets its own flag at the end of every period.
// - The group enable is bit 6 of the second interrupt-enable register; 0 blocks requests.
module sixteen_bit_pwm_trio
    import pwm_trio_pkg::*;
#(
    parameter int NUM_CH = CHANNELS,
    parameter int WIDTH = COUNT_WIDTH
) (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic [7:0] sfrAddr,
    input wire logic sfrWrite,
    input wire logic sfrRead,
    input wire logic [7:0] sfrWdata,
    output logic [7:0] sfrRdata,
    input wire logic fastOscTick,
    input wire logic fastOscDoubleTick,
    output logic pinP12Out,
    output logic pinP12Oe,
    output logic pinP13Out,
    output logic pinP13Oe,
    output logic pinP16Out,
    output logic pinP16Oe,
    output logic [2:0] channelIrq,
    output logic waveformIrq
);
    pwm_chan_if #(.CHANNELS(NUM_CH), .WIDTH(WIDTH)) chanBus ();

    logic [2:0] periodFlag_reg, periodFlag_next;
    logic [7:0] outIrqEn_reg, outIrqEn_next;
    logic [7:0] holdIrqEn_reg, holdIrqEn_next;
    logic [5:0] clockSelect_reg, clockSelect_next;
    logic groupIrqEnable_reg, groupIrqEnable_next;
    logic [7:0] holdLatch_reg, holdLatch_next;
    logic [7:0] rdata_reg, rdata_next;
    logic [WIDTH-1:0] dutyBuf_reg [NUM_CH];
    logic [WIDTH-1:0] dutyBuf_next [NUM_CH];
    logic [WIDTH-1:0] periodBuf_reg [NUM_CH];
    logic [WIDTH-1:0] periodBuf_next [NUM_CH];

    logic [2:0] outputEnable;
    logic [2:0] clearHold;
    logic [2:0] irqEnable;
    logic [2:0] wave;

    assign outputEnable = outIrqEn_reg[2:0];
    assign clearHold = holdIrqEn_reg[2:0];
    assign irqEnable = {holdIrqEn_reg[POS_CH2_IRQ_ENABLE], outIrqEn_reg[POS_CH1_IRQ_ENABLE],
                        outIrqEn_reg[POS_CH0_IRQ_ENABLE]};

    genvar ch;
    generate
        for (ch = 0; ch < NUM_CH; ch++) begin : g_chan
            logic [1:0] cks;
            assign cks = clockSelect_reg[ch*CLOCK_SOURCE_WIDTH +: CLOCK_SOURCE_WIDTH];
            // run only when enabled and not held
            assign chanBus.run[ch] = outputEnable[ch] & ~clearHold[ch];
            always_comb begin
                unique case (cks)
                    CKS_FAST_OSC: chanBus.tick[ch] = fastOscTick;
                    CKS_FAST_OSC_DOUBLE: chanBus.tick[ch] = fastOscDoubleTick;
                    default: chanBus.tick[ch] = 1'b1;
                endcase
            end
            assign chanBus.dutyBuf[ch] = dutyBuf_reg[ch];
            assign chanBus.periodBuf[ch] = periodBuf_reg[ch];
            pwm_channel #(.IDX(ch), .WIDTH(WIDTH)) u_chan (
                .ref_clk(ref_clk),
                .rstn(rstn),
                .bus(chanBus.chan)
            );
            assign channelIrq[ch] = periodFlag_reg[ch] & irqEnable[ch] & groupIrqEnable_reg;
        end
    endgenerate

    assign wave = chanBus.wave;
    assign waveformIrq = |channelIrq;

    // pin mapping, drive only when enabled
    assign pinP12Out = wave[0];
    assign pinP12Oe = outputEnable[0];
    assign pinP13Out = wave[1];
    assign pinP13Oe = outputEnable[1];
    assign pinP16Out = wave[2];
    assign pinP16Oe = outputEnable[2];
    assign sfrRdata = rdata_reg;

    always_comb begin
        periodFlag_next = periodFlag_reg;
        outIrqEn_next = outIrqEn_reg;
        holdIrqEn_next = holdIrqEn_reg;
        clockSelect_next = clockSelect_reg;
        groupIrqEnable_next = groupIrqEnable_reg;
        holdLatch_next = holdLatch_reg;
        rdata_next = rdata_reg;
        dutyBuf_next = dutyBuf_reg;
        periodBuf_next = periodBuf_reg;

        if (sfrWrite) begin
            unique case (sfrAddr)
                ADDR_PERIOD_FLAGS: periodFlag_next = periodFlag_reg & sfrWdata[2:0];
                ADDR_OUTPUT_IRQ_ENABLE: outIrqEn_next = sfrWdata & 8'hc7;
                ADDR_HOLD_IRQ_ENABLE: holdIrqEn_next = sfrWdata & 8'h87;
                ADDR_CLOCK_SELECT: clockSelect_next = sfrWdata[5:0];
                ADDR_IRQ_ENABLE_TWO: groupIrqEnable_next = sfrWdata[POS_GROUP_IRQ_ENABLE];
                default: ;
            endcase
            for (int i = 0; i < NUM_CH; i++) begin
                // low byte to latch, high byte commits
                if (sfrAddr == ADDR_DUTY_LOW_BASE + 8'(i) * ADDR_CHANNEL_STRIDE) begin
                    holdLatch_next = sfrWdata;
                end
                if (sfrAddr == ADDR_PERIOD_LOW_BASE + 8'(i) * ADDR_CHANNEL_STRIDE) begin
                    holdLatch_next = sfrWdata;
                end
                // commit lands in the shadow buffer
                if (sfrAddr == ADDR_DUTY_HIGH_BASE + 8'(i) * ADDR_CHANNEL_STRIDE) begin
                    dutyBuf_next[i] = {sfrWdata, holdLatch_reg};
                end
                if (sfrAddr == ADDR_PERIOD_HIGH_BASE + 8'(i) * ADDR_CHANNEL_STRIDE) begin
                    periodBuf_next[i] = {sfrWdata, holdLatch_reg};
                end
            end
        end

        // set wins over a same-cycle clear
        periodFlag_next = periodFlag_next | chanBus.wrap;

        if (sfrRead) begin
            rdata_next = 8'h00;
            unique case (sfrAddr)
                ADDR_PERIOD_FLAGS: rdata_next = {5'h00, periodFlag_reg};
                ADDR_OUTPUT_IRQ_ENABLE: rdata_next = outIrqEn_reg;
                ADDR_HOLD_IRQ_ENABLE: rdata_next = holdIrqEn_reg;
                ADDR_CLOCK_SELECT: rdata_next = {2'h0, clockSelect_reg};
                ADDR_IRQ_ENABLE_TWO: rdata_next = {1'b0, groupIrqEnable_reg, 6'h00};
                default: ;
            endcase
            for (int i = 0; i < NUM_CH; i++) begin
                if (sfrAddr == ADDR_DUTY_HIGH_BASE + 8'(i) * ADDR_CHANNEL_STRIDE) begin
                    rdata_next = dutyBuf_reg[i][15:8];
                    holdLatch_next = dutyBuf_reg[i][7:0];
                end
                if (sfrAddr == ADDR_PERIOD_HIGH_BASE + 8'(i) * ADDR_CHANNEL_STRIDE) begin
                    rdata_next = periodBuf_reg[i][15:8];
                    holdLatch_next = periodBuf_reg[i][7:0];
                end
                if (sfrAddr == ADDR_DUTY_LOW_BASE + 8'(i) * ADDR_CHANNEL_STRIDE ||
                    sfrAddr == ADDR_PERIOD_LOW_BASE + 8'(i) * ADDR_CHANNEL_STRIDE) begin
                    rdata_next = holdLatch_reg;
                end
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            periodFlag_reg <= RESET_PERIOD_FLAGS[2:0];
            outIrqEn_reg <= RESET_OUTPUT_IRQ_ENABLE;
            holdIrqEn_reg <= RESET_HOLD_IRQ_ENABLE;
            clockSelect_reg <= RESET_CLOCK_SELECT[5:0];
            groupIrqEnable_reg <= 1'b0;
            holdLatch_reg <= RESET_HOLD_LATCH;
            rdata_reg <= 8'h00;
            for (int i = 0; i < NUM_CH; i++) begin
                dutyBuf_reg[i] <= RESET_DUTY;
                periodBuf_reg[i] <= RESET_PERIOD;
            end
        end else begin
            periodFlag_reg <= periodFlag_next;
            outIrqEn_reg <= outIrqEn_next;
            holdIrqEn_reg <= holdIrqEn_next;
            clockSelect_reg <= clockSelect_next;
            groupIrqEnable_reg <= groupIrqEnable_next;
            holdLatch_reg <= holdLatch_next;
            rdata_reg <= rdata_next;
            dutyBuf_reg <= dutyBuf_next;
            periodBuf_reg <= periodBuf_next;
        end
    end
endmodule : sixteen_bit_pwm_trio

//--- design/pwm_trio_pkg.sv
package pwm_trio_pkg;

    localparam int CHANNELS = 3;
    localparam int COUNT_WIDTH = 16;

    // special-register addresses
    localparam logic [7:0] ADDR_PERIOD_FLAGS = 8'h86;
    localparam logic [7:0] ADDR_OUTPUT_IRQ_ENABLE = 8'h9e;
    localparam logic [7:0] ADDR_HOLD_IRQ_ENABLE = 8'h9f;
    localparam logic [7:0] ADDR_CLOCK_SELECT = 8'ha1;
    localparam logic [7:0] ADDR_IRQ_ENABLE_TWO = 8'ha9;
    localparam logic [7:0] ADDR_DUTY_HIGH_BASE = 8'hd1;
    localparam logic [7:0] ADDR_DUTY_LOW_BASE = 8'hd2;
    localparam logic [7:0] ADDR_PERIOD_HIGH_BASE = 8'hd9;
    localparam logic [7:0] ADDR_PERIOD_LOW_BASE = 8'hda;
    localparam logic [7:0] ADDR_CHANNEL_STRIDE = 8'h02;

    // field positions
    localparam int POS_CH0_IRQ_ENABLE = 6;
    localparam int POS_CH1_IRQ_ENABLE = 7;
    localparam int POS_CH2_IRQ_ENABLE = 7;
    localparam int POS_GROUP_IRQ_ENABLE = 6;
    localparam int CLOCK_SOURCE_WIDTH = 2;

    // reset values
    localparam logic [7:0] RESET_PERIOD_FLAGS = 8'h00;
    localparam logic [7:0] RESET_OUTPUT_IRQ_ENABLE = 8'h00;
    localparam logic [7:0] RESET_HOLD_IRQ_ENABLE = 8'h00;
    localparam logic [7:0] RESET_CLOCK_SELECT = 8'h2a;
    localparam logic [7:0] RESET_HOLD_LATCH = 8'h00;
    localparam logic [15:0] RESET_DUTY = 16'h8000;
    localparam logic [15:0] RESET_PERIOD = 16'hffff;

    // clock-source codes
    localparam logic [1:0] CKS_SYSTEM_A = 2'h0;
    localparam logic [1:0] CKS_SYSTEM_B = 2'h1;
    localparam logic [1:0] CKS_FAST_OSC = 2'h2;
    localparam logic [1:0] CKS_FAST_OSC_DOUBLE = 2'h3;

endpackage : pwm_trio_pkg

//--- design/pwm_chan_if.sv
`timescale 1ns/1ps
interface pwm_chan_if #(
    parameter int CHANNELS = 3,
    parameter int WIDTH = 16
);
    logic [CHANNELS-1:0] run;
    logic [CHANNELS-1:0] tick;
    logic [WIDTH-1:0] dutyBuf [CHANNELS];
    logic [WIDTH-1:0] periodBuf [CHANNELS];
    logic [CHANNELS-1:0] wrap;
    logic [CHANNELS-1:0] wave;

    modport ctrl (
        output run,
        output tick,
        output dutyBuf,
        output periodBuf,
        input wrap,
        input wave
    );

    modport chan (
        input run,
        input tick,
        input dutyBuf,
        input periodBuf,
        output wrap,
        output wave
    );
endinterface : pwm_chan_if

//--- design/pwm_channel.sv
`timescale 1ns/1ps
module pwm_channel
    import pwm_trio_pkg::*;
#(
    parameter int IDX = 0,
    parameter int WIDTH = 16
) (
    input wire logic ref_clk,
    input wire logic rstn,
    pwm_chan_if.chan bus
);
    logic [WIDTH-1:0] count_reg, count_next;
    logic [WIDTH-1:0] duty_reg, duty_next;
    logic [WIDTH-1:0] period_reg, period_next;
    logic wave_reg, wave_next;
    logic started_reg, started_next;
    logic wrap_reg, wrap_next;

    always_comb begin
        count_next = count_reg;
        duty_next = duty_reg;
        period_next = period_reg;
        wave_next = wave_reg;
        started_next = started_reg;
        wrap_next = 1'b0;
        if (!bus.run[IDX]) begin
            count_next = '0;
            wave_next = 1'b0;
            started_next = 1'b0;
            duty_next = bus.dutyBuf[IDX];
            period_next = bus.periodBuf[IDX];
        end else if (!started_reg) begin
            started_next = 1'b1;
            wave_next = (duty_reg != '0);
        end else if (bus.tick[IDX]) begin
            if (count_reg == period_reg) begin
                count_next = '0;
                wrap_next = 1'b1;
                duty_next = bus.dutyBuf[IDX];
                period_next = bus.periodBuf[IDX];
                wave_next = (bus.dutyBuf[IDX] != '0);
            end else begin
                count_next = count_reg + 1'b1;
                if (count_next == duty_reg) begin
                    wave_next = 1'b0;
                end
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            count_reg <= '0;
            duty_reg <= RESET_DUTY;
            period_reg <= RESET_PERIOD;
            wave_reg <= 1'b0;
            started_reg <= 1'b0;
            wrap_reg <= 1'b0;
        end else begin
            count_reg <= count_next;
            duty_reg <= duty_next;
            period_reg <= period_next;
            wave_reg <= wave_next;
            started_reg <= started_next;
            wrap_reg <= wrap_next;
        end
    end

    assign bus.wave[IDX] = wave_reg;
    assign bus.wrap[IDX] = wrap_reg;
endmodule : pwm_channel

//--- verif/pwm_trio_properties.sv
`timescale 1ns/1ps
module pwm_trio_properties
    import pwm_trio_pkg::*;
#(
    parameter int NUM_CH = CHANNELS,
    parameter int WIDTH = COUNT_WIDTH
) (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic [7:0] sfrAddr,
    input wire logic sfrWrite,
    input wire logic sfrRead,
    input wire logic [7:0] sfrWdata,
    input wire logic [7:0] sfrRdata,
    input wire logic fastOscTick,
    input wire logic fastOscDoubleTick,
    input wire logic pinP12Out,
    input wire logic pinP12Oe,
    input wire logic pinP13Out,
    input wire logic pinP13Oe,
    input wire logic pinP16Out,
    input wire logic pinP16Oe,
    input wire logic [2:0] channelIrq,
    input wire logic waveformIrq
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    wire wrOe = sfrWrite && sfrAddr == ADDR_OUTPUT_IRQ_ENABLE;
    wire wrHold = sfrWrite && sfrAddr == ADDR_HOLD_IRQ_ENABLE;
    wire wrGroup = sfrWrite && sfrAddr == ADDR_IRQ_ENABLE_TWO;

    AST_IRQ_OR: assert property (waveformIrq == |channelIrq)
        else $error("group request differs from OR of channel requests");
    AST_OE_WRITE: assert property (
        wrOe |=> {pinP16Oe, pinP13Oe, pinP12Oe} == $past(sfrWdata[2:0]))
        else $error("pin enables do not follow the written enable bits");
    AST_OE_HOLD: assert property (!wrOe |=> $stable({pinP16Oe, pinP13Oe, pinP12Oe}))
        else $error("pin enables changed without a write");
    // two extra edges allow for the registered waveform path
    AST_IDLE_P12: assert property (!pinP12Oe [*3] |-> !pinP12Out)
        else $error("channel zero pin active while disabled");
    AST_IDLE_P16: assert property (!pinP16Oe [*3] |-> !pinP16Out)
        else $error("channel two pin active while disabled");
    AST_RDATA_HOLD: assert property (!sfrRead |=> $stable(sfrRdata))
        else $error("read data changed without a read");
    AST_FLAG_RSVD: assert property (
        sfrRead && sfrAddr == ADDR_PERIOD_FLAGS |=> sfrRdata[7:3] == 5'h00)
        else $error("unused flag bits read nonzero");
    AST_GROUP_BLOCK: assert property (
        wrGroup && !sfrWdata[POS_GROUP_IRQ_ENABLE] |=> channelIrq == 3'h0)
        else $error("request raised with group enable off");
    AST_HOLD_P12: assert property (wrHold && sfrWdata[0] |-> ##3 !pinP12Out)
        else $error("channel zero pin not cleared by hold");

    cover property (wrOe && sfrWdata[0]);
    cover property (channelIrq[0]);
    cover property ($rose(pinP13Out));
endmodule : pwm_trio_properties

bind sixteen_bit_pwm_trio pwm_trio_properties #(.NUM_CH(NUM_CH), .WIDTH(WIDTH)) u_props (
    .ref_clk, .rstn, .sfrAddr, .sfrWrite, .sfrRead, .sfrWdata, .sfrRdata,
    .fastOscTick, .fastOscDoubleTick, .pinP12Out, .pinP12Oe, .pinP13Out,
    .pinP13Oe, .pinP16Out, .pinP16Oe, .channelIrq, .waveformIrq);

//--- verif/pin_load.sv
`timescale 1ns/1ps
module pin_load (
    input wire logic out,
    input wire logic oe,
    output logic pad
);
    // an undriven pad settles through the board pull-down
    assign pad = oe ? out : 1'b0;
endmodule : pin_load

//--- verif/tb_top.sv
`timescale 1ns/1ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin bad_count++; \
    $display("ERROR %0t: got %h want %h", $time, g, e); end end
module tb_top;
    import pwm_trio_pkg::*;
    logic ref_clk = 1'b0, rstn = 1'b0, sfrWrite = 1'b0, sfrRead = 1'b0;
    logic fastOscTick = 1'b0, fastOscDoubleTick = 1'b0, wIrq;
    logic [7:0] sfrAddr = 8'h00, sfrWdata = 8'h00, sfrRdata, d;
    wire [2:0] oe, out, pad, irq;
    int bad_count = 0, checked = 0, tickCnt = 0, len, hi;

    always #5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        tickCnt <= tickCnt + 1;
        fastOscTick <= (tickCnt % 4 == 0);
        fastOscDoubleTick <= (tickCnt % 2 == 0);
    end

    sixteen_bit_pwm_trio i_dut (
        .ref_clk, .rstn, .sfrAddr, .sfrWrite, .sfrRead, .sfrWdata, .sfrRdata,
        .fastOscTick, .fastOscDoubleTick, .pinP12Out(out[0]), .pinP12Oe(oe[0]),
        .pinP13Out(out[1]), .pinP13Oe(oe[1]), .pinP16Out(out[2]), .pinP16Oe(oe[2]),
        .channelIrq(irq), .waveformIrq(wIrq));
    for (genvar i = 0; i < 3; i++) begin : g_load
        pin_load i_load (.out(out[i]), .oe(oe[i]), .pad(pad[i]));
    end

    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge ref_clk);
        sfrAddr <= a;
        sfrWdata <= v;
        sfrWrite <= 1'b1;
        @(posedge ref_clk);
        sfrWrite <= 1'b0;
    endtask : wr

    task automatic chk_rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge ref_clk);
        sfrAddr <= a;
        sfrRead <= 1'b1;
        @(posedge ref_clk);
        sfrRead <= 1'b0;
        #1 d = sfrRdata;
        `CHK(d, e)
    endtask : chk_rd

    task automatic results;
        $display("counts: checked %0d bad_count %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : results

    // length and high time of one full period, from rising edge to rising edge
    task automatic measure(input int ch);
        int n;
        logic p;
        p = 1'b1;
        #1;
        for (n = 0; n < 400 && !(pad[ch] && !p); n++) begin
            p = pad[ch];
            @(posedge ref_clk);
            #1;
        end
        len = 0;
        hi = 0;
        do begin
            hi += pad[ch];
            len++;
            p = pad[ch];
            @(posedge ref_clk);
            #1;
        end while (!(pad[ch] && !p) && len < 400);
        if (n == 400 || len == 400) begin
            bad_count++;
            $display("ERROR %0t: waveform stalled", $time);
            results();
        end
    endtask : measure

    initial begin
        repeat (12) @(posedge ref_clk);
        rstn <= 1'b1;
        chk_rd(8'h86, 8'h00);
        chk_rd(8'h9e, 8'h00);
        chk_rd(8'h9f, 8'h00);
        chk_rd(8'ha1, 8'h2a);
        chk_rd(8'h00, 8'h00);
        chk_rd(ADDR_DUTY_HIGH_BASE + 8'h04, 8'h80);
        chk_rd(ADDR_PERIOD_HIGH_BASE, 8'hff);
        chk_rd(ADDR_PERIOD_LOW_BASE, 8'hff);
        $display("test reset finished");
        wr(8'hd4, 8'h34);
        wr(8'hd3, 8'h12);
        chk_rd(8'hd3, 8'h12);
        chk_rd(8'hd4, 8'h34);
        // a lone low write must leave the committed value alone
        wr(8'hd4, 8'h56);
        chk_rd(8'hd3, 8'h12);
        chk_rd(8'hd4, 8'h34);
        wr(8'h9e, 8'hf8);
        chk_rd(8'h9e, 8'hc0);
        wr(8'h9f, 8'hf8);
        chk_rd(8'h9f, 8'h80);
        wr(8'ha1, 8'hff);
        chk_rd(8'ha1, 8'h3f);
        $display("test access finished");
        wr(8'h9f, 8'h01);
        wr(ADDR_PERIOD_LOW_BASE, 8'h04);
        wr(ADDR_PERIOD_HIGH_BASE, 8'h00);
        wr(ADDR_DUTY_LOW_BASE, 8'h02);
        wr(ADDR_DUTY_HIGH_BASE, 8'h00);
        wr(8'ha1, 8'h00);
        wr(8'h9e, 8'h41);
        wr(8'h9f, 8'h00);
        measure(0);
        `CHK(len, 5)
        `CHK(hi, 2)
        wr(ADDR_DUTY_LOW_BASE, 8'h03);
        wr(ADDR_DUTY_HIGH_BASE, 8'h00);
        measure(0);
        `CHK(hi, 3)
        for (int c = 1; c < 4; c++) begin
            wr(8'ha1, 8'(c));
            measure(0);
            measure(0);
            `CHK(len, (c == 1) ? 5 : (c == 2) ? 20 : 10)
        end
        $display("test wave finished");
        `CHK(irq, 3'h0)
        chk_rd(8'h86, 8'h01);
        wr(ADDR_IRQ_ENABLE_TWO, 8'h40);
        #1;
        `CHK(irq, 3'h1)
        `CHK(wIrq, 1'b1)
        wr(ADDR_IRQ_ENABLE_TWO, 8'h00);
        #1;
        `CHK(irq, 3'h0)
        wr(ADDR_IRQ_ENABLE_TWO, 8'h40);
        chk_rd(ADDR_IRQ_ENABLE_TWO, 8'h40);
        wr(8'h9f, 8'h01);
        wr(8'h86, 8'h00);
        #1;
        `CHK(irq, 3'h0)
        `CHK(pad[0], 1'b0)
        chk_rd(8'h86, 8'h00);
        $display("test flags finished");
        wr(8'h9e, 8'h07);
        wr(8'h9f, 8'h00);
        repeat (4) @(posedge ref_clk);
        #1;
        `CHK(oe, 3'h7)
        `CHK(pad[2:1], 2'h3)
        wr(8'h9e, 8'h00);
        repeat (3) @(posedge ref_clk);
        #1;
        `CHK({oe, pad}, 6'h00)
        $display("test pins finished");
        results();
    end
endmodule : tb_top
